/* File: awr_pkg.sv */
// Purpose: Shared constants and types for the alarm window register bank.
// Assumes: Byte-wide register port with 8-bit addresses.
// Notes: Offsets are byte addresses in the device register map.
package awr_pkg;
   localparam logic [7:0] ADDR_P_WIN_HIGH = 8'h19;
   localparam logic [7:0] ADDR_P_WIN_LOW = 8'h1a;
   localparam logic [7:0] ADDR_TEMP_WIN = 8'h1b;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam int P_WIN_HIGH_MSB = 15;
   localparam int P_WIN_HIGH_LSB = 8;
   localparam int P_WIN_LOW_MSB = 7;
   localparam int P_WIN_LOW_LSB = 0;

   // Window unit select: whole meters or 2 Pa steps.
   typedef enum logic [1:0] {
      AWR_UNIT_METER = 2'b01,
      AWR_UNIT_2PA = 2'b10
   } awr_unit_t;

   // Register access request from the serial interface front end.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } awr_req_t;

   // Whole state of the register bank.
   typedef struct packed {
      logic [7:0] p_win_high;
      logic [7:0] p_win_low;
      logic [7:0] temp_win;
      logic [7:0] rdata;
      logic hit;
   } awr_state_t;
endpackage

/* File: awr_alarm_window_registers.sv */
// Purpose: Alarm window registers for pressure/altitude and temperature.
// Assumes: Requests are synchronous to mclk and last one cycle each.
// Notes: Read data is registered and appears one cycle after the request.
`timescale 1ns/1ps
module awr_alarm_window_registers (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Register access
   input wire awr_pkg::awr_req_t req,
   output logic [7:0] rdata,
   output logic rhit,
   // Mode and window outputs to the alarm comparator
   input wire logic altimeter_mode,
   output logic [15:0] pressure_window,
   output logic [7:0] temperature_window,
   output awr_pkg::awr_unit_t pressure_window_unit
);
   awr_pkg::awr_state_t st;
   awr_pkg::awr_state_t next_st;

   function automatic logic addr_is(input logic [7:0] a, input logic [7:0] b);
      return a == b;
   endfunction

   // True for the three window addresses; every other address is unmapped.
   function automatic logic is_mapped(input logic [7:0] a);
      return addr_is(a, awr_pkg::ADDR_P_WIN_HIGH)
         || addr_is(a, awr_pkg::ADDR_P_WIN_LOW)
         || addr_is(a, awr_pkg::ADDR_TEMP_WIN);
   endfunction

   always_comb begin
      next_st = st;
      next_st.hit = 1'b0;
      // Only host writes and reset change the windows; nothing else touches them.
      if (req.wr) begin
         if (addr_is(req.addr, awr_pkg::ADDR_P_WIN_HIGH)) begin
            next_st.p_win_high = req.wdata;
         end
         if (addr_is(req.addr, awr_pkg::ADDR_P_WIN_LOW)) begin
            next_st.p_win_low = req.wdata;
         end
         if (addr_is(req.addr, awr_pkg::ADDR_TEMP_WIN)) begin
            next_st.temp_win = req.wdata;
         end
      end
      if (req.rd) begin
         next_st.hit = 1'b1;
         case (req.addr)
            awr_pkg::ADDR_P_WIN_HIGH: next_st.rdata = st.p_win_high;
            awr_pkg::ADDR_P_WIN_LOW: next_st.rdata = st.p_win_low;
            awr_pkg::ADDR_TEMP_WIN: next_st.rdata = st.temp_win;
            default: begin
               // Unmapped addresses read as zero and report no hit.
               next_st.rdata = 8'h00;
               next_st.hit = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st.p_win_high <= awr_pkg::RESET_BYTE;
         st.p_win_low <= awr_pkg::RESET_BYTE;
         st.temp_win <= awr_pkg::RESET_BYTE;
         st.rdata <= awr_pkg::RESET_BYTE;
         st.hit <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign rdata = st.rdata;
   assign rhit = st.hit;
   // Plain zero-extended concatenation: no sign bit anywhere.
   assign pressure_window = {st.p_win_high, st.p_win_low};
   assign temperature_window = st.temp_win;
   assign pressure_window_unit = altimeter_mode ? awr_pkg::AWR_UNIT_METER
                                                : awr_pkg::AWR_UNIT_2PA;

   // One clock domain, so every assertion below shares these defaults.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence wr_high_s;
      req.wr && req.addr == awr_pkg::ADDR_P_WIN_HIGH;
   endsequence
   sequence wr_low_s;
      req.wr && req.addr == awr_pkg::ADDR_P_WIN_LOW;
   endsequence
   sequence wr_temp_s;
      req.wr && req.addr == awr_pkg::ADDR_TEMP_WIN;
   endsequence
   sequence wr_unmapped_s;
      req.wr && !is_mapped(req.addr);
   endsequence
   sequence rd_high_s;
      req.rd && req.addr == awr_pkg::ADDR_P_WIN_HIGH;
   endsequence
   sequence rd_low_s;
      req.rd && req.addr == awr_pkg::ADDR_P_WIN_LOW;
   endsequence
   sequence rd_temp_s;
      req.rd && req.addr == awr_pkg::ADDR_TEMP_WIN;
   endsequence
   sequence rd_unmapped_s;
      req.rd && !is_mapped(req.addr);
   endsequence

   property high_write_p;
      wr_high_s |=> pressure_window[awr_pkg::P_WIN_HIGH_MSB:
         awr_pkg::P_WIN_HIGH_LSB] == $past(req.wdata);
   endproperty
   high_write_a: assert property (high_write_p)
      else $error("high window byte not written");

   property low_write_p;
      wr_low_s |=> pressure_window[awr_pkg::P_WIN_LOW_MSB:
         awr_pkg::P_WIN_LOW_LSB] == $past(req.wdata);
   endproperty
   low_write_a: assert property (low_write_p)
      else $error("low window byte not written");

   property temp_write_p;
      wr_temp_s |=> temperature_window == $past(req.wdata);
   endproperty
   temp_write_a: assert property (temp_write_p)
      else $error("temperature window not written");

   // A set top bit must not spill into the low byte, as a sign would.
   property unsigned_value_p;
      wr_high_s |=> pressure_window == {$past(req.wdata),
         $past(pressure_window[awr_pkg::P_WIN_LOW_MSB:
         awr_pkg::P_WIN_LOW_LSB])};
   endproperty
   unsigned_value_a: assert property (unsigned_value_p)
      else $error("pressure window not plain unsigned");

   property high_isolate_p;
      wr_high_s |=> $stable(temperature_window);
   endproperty
   high_isolate_a: assert property (high_isolate_p)
      else $error("high byte write disturbed temperature");

   property low_isolate_p;
      wr_low_s |=> $stable(pressure_window[awr_pkg::P_WIN_HIGH_MSB:
         awr_pkg::P_WIN_HIGH_LSB]) && $stable(temperature_window);
   endproperty
   low_isolate_a: assert property (low_isolate_p)
      else $error("low byte write disturbed another window");

   property temp_isolate_p;
      wr_temp_s |=> $stable(pressure_window);
   endproperty
   temp_isolate_a: assert property (temp_isolate_p)
      else $error("temperature write disturbed pressure");

   property window_hold_p;
      !req.wr |=> $stable(pressure_window) && $stable(temperature_window);
   endproperty
   window_hold_a: assert property (window_hold_p)
      else $error("window changed without a write");

   property unmapped_write_p;
      wr_unmapped_s |=> $stable(pressure_window)
         && $stable(temperature_window);
   endproperty
   unmapped_write_a: assert property (unmapped_write_p)
      else $error("unmapped write changed a window");

   property reset_zero_p;
      $rose(rst_n) |-> pressure_window == {2{awr_pkg::RESET_BYTE}}
         && temperature_window == awr_pkg::RESET_BYTE;
   endproperty
   reset_zero_a: assert property (reset_zero_p)
      else $error("windows not zero after reset");

   property reset_quiet_p;
      $rose(rst_n) |-> rdata == awr_pkg::RESET_BYTE && !rhit;
   endproperty
   reset_quiet_a: assert property (reset_quiet_p)
      else $error("read port not quiet after reset");

   property readback_high_p;
      rd_high_s |=> rhit && rdata == $past(pressure_window[
         awr_pkg::P_WIN_HIGH_MSB:awr_pkg::P_WIN_HIGH_LSB]);
   endproperty
   readback_high_a: assert property (readback_high_p)
      else $error("high byte readback wrong");

   property readback_low_p;
      rd_low_s |=> rhit && rdata == $past(pressure_window[
         awr_pkg::P_WIN_LOW_MSB:awr_pkg::P_WIN_LOW_LSB]);
   endproperty
   readback_low_a: assert property (readback_low_p)
      else $error("low byte readback wrong");

   property readback_temp_p;
      rd_temp_s |=> rhit && rdata == $past(temperature_window);
   endproperty
   readback_temp_a: assert property (readback_temp_p)
      else $error("temperature readback wrong");

   property unmapped_read_p;
      rd_unmapped_s |=> !rhit && rdata == 8'h00;
   endproperty
   unmapped_read_a: assert property (unmapped_read_p)
      else $error("unmapped read gave data or hit");

   // The hit is a pulse; a level would hide a second read from the host.
   property hit_pulse_p;
      !req.rd |=> !rhit;
   endproperty
   hit_pulse_a: assert property (hit_pulse_p)
      else $error("hit stayed high without a read");

   property rdata_hold_p;
      !req.rd |=> $stable(rdata);
   endproperty
   rdata_hold_a: assert property (rdata_hold_p)
      else $error("read data changed without a read");

   property unit_select_p;
      altimeter_mode ? pressure_window_unit == awr_pkg::AWR_UNIT_METER
         : pressure_window_unit == awr_pkg::AWR_UNIT_2PA;
   endproperty
   unit_select_a: assert property (unit_select_p)
      else $error("window unit wrong for mode");
endmodule // awr_alarm_window_registers

/* File: awr_host.sv */
// Purpose: Host model that issues register requests.
// Assumes: One request at a time, driven 1 ns after mclk rises.
// Notes: Idle addr and wdata carry the inverse of the last values, not stale data; wr and rd drop to 0.
`timescale 1ns/1ps
module awr_host (
   // Clock
   input wire logic mclk,
   // Register access
   output awr_pkg::awr_req_t req
);
   initial req = '0;
   task automatic xfer(input logic w, input logic [7:0] a, d);
      @(posedge mclk) #1;
      req = '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge mclk) #1;
      req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
endmodule // awr_host

/* File: tb.sv */
// Purpose: Self-checking bench for the alarm window registers.
// Assumes: Outputs settle one cycle after the request is taken.
// Notes: A model array tracks the three bytes; neighbours stay unmapped.
`timescale 1ns/1ps
module tb;
   logic mclk, rst_n, alt, rhit;
   awr_pkg::awr_req_t req;
   awr_pkg::awr_unit_t unit;
   logic [7:0] rdata, tw, d, mr[3];
   logic [15:0] pw;
   int miscompares, n_tests, k;
   logic [7:0] adr[5] = '{awr_pkg::ADDR_P_WIN_HIGH, awr_pkg::ADDR_P_WIN_LOW,
      awr_pkg::ADDR_TEMP_WIN, 8'h18, 8'h1c};
   awr_host host (.mclk(mclk), .req(req));
   awr_alarm_window_registers dut (.mclk(mclk), .rst_n(rst_n), .req(req),
      .rdata(rdata), .rhit(rhit), .altimeter_mode(alt),
      .pressure_window(pw), .temperature_window(tw),
      .pressure_window_unit(unit));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   function automatic logic [8:0] exp_rd(input logic [7:0] a);
      int i = int'(a) - int'(awr_pkg::ADDR_P_WIN_HIGH);
      return (i >= 0 && i < 3) ? {1'b1, mr[i]} : 9'h000;
   endfunction
   task automatic chk(input string s, input logic [15:0] e, g);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic outs();
      chk("pw", {mr[0], mr[1]}, pw);
      chk("tw", {8'h00, mr[2]}, tw);
      chk("unit", {14'h0000, alt ? awr_pkg::AWR_UNIT_METER :
         awr_pkg::AWR_UNIT_2PA}, {14'h0000, unit});
   endtask
   task automatic rd(input logic [7:0] a);
      logic [8:0] e;
      e = exp_rd(a);
      host.xfer(1'b0, a, 8'h00);
      chk("rdata", {8'h00, e[7:0]}, {8'h00, rdata});
      chk("rhit", {15'h0000, e[8]}, {15'h0000, rhit});
      @(posedge mclk) #1;
      chk("rhit_drop", 16'h0000, {15'h0000, rhit});
      chk("rdata_hold", {8'h00, e[7:0]}, {8'h00, rdata});
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      rst_n = 1'b0;
      alt = 1'b0;
      mr = '{default: 8'h00};
      repeat (6) @(posedge mclk);
      #1 rst_n = 1'b1;
      void'($urandom(99));
      foreach (adr[i]) rd(adr[i]);
      outs();
      $display("reset values test done");
      // Top bits set: a signed view would show up in the wide value.
      alt = 1'b1;
      host.xfer(1'b1, adr[0], 8'hff);
      mr[0] = 8'hff;
      host.xfer(1'b1, adr[1], 8'h01);
      mr[1] = 8'h01;
      host.xfer(1'b1, adr[2], 8'h80);
      mr[2] = 8'h80;
      host.xfer(1'b1, adr[4], 8'h3c);
      outs();
      foreach (adr[i]) rd(adr[i]);
      $display("corner case test done");
      repeat (80) begin
         k = $urandom % 5;
         d = 8'($urandom);
         alt = 1'($urandom);
         if ($urandom % 2) begin
            host.xfer(1'b1, adr[k], d);
            if (k < 3) mr[k] = d;
         end
         else rd(adr[k]);
         outs();
      end
      $display("random access test done");
      host.xfer(1'b1, adr[0], 8'h5a);
      mr[0] = 8'h5a;
      rd(adr[0]);
      rst_n = 1'b0;
      @(posedge mclk) #1;
      rst_n = 1'b1;
      mr = '{default: 8'h00};
      outs();
      chk("rdata_rst", 16'h0000, {8'h00, rdata});
      chk("rhit_rst", 16'h0000, {15'h0000, rhit});
      $display("mid-run reset test done");
      test_done();
   end
endmodule // tb
